// ==== dbs_pkg.sv ====
package dbs_pkg;
    localparam int ADDR_W            = 20;
    localparam int WORD_W            = 18;
    localparam int BYTE_W            = 9;
    localparam int LANES             = 2;
    localparam int BURST_W           = 36;
    localparam int CLK_NS            = 20;
    localparam int K_PERIOD_NS       = 160;
    localparam int K_PERIOD_CYC      = K_PERIOD_NS / CLK_NS;
    localparam int K_HALF_CYC        = K_PERIOD_CYC / 2;
    localparam int DLL_RESET_NS      = 30;
    localparam int DLL_RESET_CYC     = (DLL_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int STALL_CYC         = K_HALF_CYC + DLL_RESET_CYC;
    localparam int LOCK_CYCLES       = 2048;
    localparam int IMP_RETUNE_CYCLES = 1024;
    localparam int TURN_NOPS         = 3;
    localparam int WDATA1_CNT        = 1;

    localparam logic [3:0] REG_ADDR   = 4'h0;
    localparam logic [3:0] REG_WDATA0 = 4'h1;
    localparam logic [3:0] REG_WDATA1 = 4'h2;
    localparam logic [3:0] REG_BWS    = 4'h3;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_RDATA0 = 4'h6;
    localparam logic [3:0] REG_RDATA1 = 4'h7;

    localparam int CTRL_GO_READ  = 0;
    localparam int CTRL_GO_WRITE = 1;
    localparam int CTRL_LOOP_ON  = 2;
    localparam int CTRL_CLK_STOP = 3;

    localparam logic [3:0]       BWS_RESET  = 4'h0;
    localparam logic [LANES-1:0] BWS_IDLE   = 2'h3;
    localparam logic             LOOP_RESET = 1'h1;
endpackage : dbs_pkg

// ==== dbs_link_if.sv ====
`timescale 1ns/100ps
interface dbs_link_if;
    logic                        k;
    logic                        kn;
    logic [dbs_pkg::ADDR_W-1:0]  addr;
    logic                        loadStrobeN;
    logic                        rw;
    logic [dbs_pkg::LANES-1:0]   byteWriteSelectN;
    logic [dbs_pkg::WORD_W-1:0]  ctlDq;
    logic                        ctlDqOe;
    logic [dbs_pkg::WORD_W-1:0]  devDq;
    logic                        devDqOe;
    logic [dbs_pkg::WORD_W-1:0]  dqBus;
    logic                        echoTimingOut;
    logic                        echoTimingOutCompl;
    logic                        readValidFlag;
    logic                        loopDisableN;

    // Shared data pins resolved here; an undriven bus reads as zero
    assign dqBus = ctlDqOe ? ctlDq : (devDqOe ? devDq : '0);

    modport dev (
        input  k, kn, addr, loadStrobeN, rw, byteWriteSelectN, dqBus, loopDisableN,
        output devDq, devDqOe, echoTimingOut, echoTimingOutCompl, readValidFlag
    );
    modport ctl (
        input  dqBus, echoTimingOut, echoTimingOutCompl, readValidFlag,
        output k, kn, addr, loadStrobeN, rw, byteWriteSelectN, ctlDq, ctlDqOe,
               loopDisableN
    );
endinterface : dbs_link_if

// ==== dbs_sync.sv ====
`timescale 1ns/100ps
module dbs_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : dbs_sync

// ==== dbs_device.sv ====
`timescale 1ns/100ps
module dbs_device #(
    parameter int LOCK_CYCLES = dbs_pkg::LOCK_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    dbs_link_if.dev   link,
    output logic      loopLocked,
    output logic      impedanceTunePulse
);
    localparam int AW = dbs_pkg::ADDR_W;
    localparam int DW = dbs_pkg::WORD_W;
    localparam int NL = dbs_pkg::LANES;
    localparam int BW = dbs_pkg::BYTE_W;
    localparam int SW = 2 + AW + 2 + NL + DW + 1;

    function automatic logic [DW-1:0] mergeBytes(input logic [DW-1:0] old,
                                                 input logic [DW-1:0] nw,
                                                 input logic [NL-1:0] en);
        logic [DW-1:0] res;
        res = old;
        for (int i = 0; i < NL; i++) begin
            if (en[i]) begin
                res[i*BW +: BW] = nw[i*BW +: BW];
            end
        end
        return res;
    endfunction : mergeBytes

    // Whole array as 18-bit words; index is pair address plus burst bit
    logic [DW-1:0] mem [0:(2**(AW+1))-1];

    wire logic [SW-1:0] rawIn = {link.k, link.kn, link.addr, link.loadStrobeN, link.rw,
                                 link.byteWriteSelectN, link.dqBus, link.loopDisableN};
    logic [SW-1:0] syncIn;

    dbs_sync #(.W(SW)) uSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (rawIn),
        .dout     (syncIn)
    );

    wire logic          kS    = syncIn[SW-1];
    wire logic          knS   = syncIn[SW-2];
    wire logic [AW-1:0] addrS = syncIn[SW-3 -: AW];
    wire logic          ldS   = syncIn[DW+NL+2];
    wire logic          rwS   = syncIn[DW+NL+1];
    wire logic [NL-1:0] bwsS  = syncIn[DW+1 +: NL];
    wire logic [DW-1:0] dqS   = syncIn[1 +: DW];
    wire logic          dllOn = syncIn[0];

    logic          kPrev_reg;
    logic          knPrev_reg;
    logic          rdV1_reg;
    logic          rdV2_reg;
    logic [AW-1:0] rdA1_reg;
    logic [AW-1:0] rdA2_reg;
    logic          outActive_reg;
    logic [AW-1:0] outAddr_reg;
    logic          wrCmdV_reg;
    logic [AW-1:0] wrCmdA_reg;
    logic          wrWord1_reg;
    logic          pendValid_reg;
    logic [AW-1:0] pendAddr_reg;
    logic [dbs_pkg::BURST_W-1:0] pendData_reg;
    logic [2*NL-1:0] pendMask_reg;
    logic [3:0]    gapCnt_reg;
    logic [11:0]   lockCnt_reg;
    logic [9:0]    impCnt_reg;

    wire logic kRise    = kS & ~kPrev_reg;
    wire logic knRise   = knS & ~knPrev_reg;
    wire logic cmdRead  = kRise & ~ldS & rwS;
    wire logic cmdWrite = kRise & ~ldS & ~rwS;

    // Read latency picked by loop mode: two rises with the loop, one without
    wire logic          drvV = dllOn ? rdV2_reg : rdV1_reg;
    wire logic [AW-1:0] drvA = dllOn ? rdA2_reg : rdA1_reg;

    wire logic hit0 = pendValid_reg && (pendAddr_reg == drvA);
    wire logic hit1 = pendValid_reg && (pendAddr_reg == outAddr_reg);
    wire logic [DW-1:0] rdWord0 = mergeBytes(mem[{drvA, 1'b0}], pendData_reg[DW-1:0],
                                             hit0 ? pendMask_reg[NL-1:0] : '0);
    // Second burst word comes from the same pair address with the burst bit set
    wire logic [DW-1:0] rdWord1 = mergeBytes(mem[{outAddr_reg, 1'b1}], pendData_reg[2*DW-1:DW],
                                             hit1 ? pendMask_reg[2*NL-1:NL] : '0);
    wire logic stalled = (gapCnt_reg == 4'(dbs_pkg::STALL_CYC));

    // Read pipeline and output drivers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            kPrev_reg     <= 1'b0;
            knPrev_reg    <= 1'b0;
            rdV1_reg      <= 1'b0;
            rdV2_reg      <= 1'b0;
            rdA1_reg      <= '0;
            rdA2_reg      <= '0;
            outActive_reg <= 1'b0;
            outAddr_reg   <= '0;
            link.devDq    <= '0;
            link.devDqOe  <= 1'b0;
            link.readValidFlag <= 1'b0;
        end else begin
            kPrev_reg  <= kS;
            knPrev_reg <= knS;
            if (kRise) begin
                rdV1_reg      <= cmdRead;
                rdA1_reg      <= addrS;
                rdV2_reg      <= rdV1_reg;
                rdA2_reg      <= rdA1_reg;
                outActive_reg <= drvV;
                outAddr_reg   <= drvA;
                link.devDqOe  <= drvV;
                if (drvV) begin
                    link.devDq <= rdWord0;
                end
            end else if (knRise) begin
                link.readValidFlag <= drvV;
                if (outActive_reg) begin
                    link.devDq <= rdWord1;
                end
            end
        end
    end

    // Write capture into the posted-write registers
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wrCmdV_reg    <= 1'b0;
            wrCmdA_reg    <= '0;
            wrWord1_reg   <= 1'b0;
            pendValid_reg <= 1'b0;
            pendAddr_reg  <= '0;
            pendData_reg  <= '0;
            pendMask_reg  <= '0;
        end else if (kRise) begin
            wrCmdV_reg <= cmdWrite;
            wrCmdA_reg <= addrS;
            if (wrCmdV_reg) begin
                pendValid_reg          <= 1'b1;
                pendAddr_reg           <= wrCmdA_reg;
                pendData_reg[DW-1:0]   <= dqS;
                pendMask_reg           <= {{NL{1'b0}}, ~bwsS};
                wrWord1_reg            <= 1'b1;
            end
        end else if (knRise && wrWord1_reg) begin
            pendData_reg[2*DW-1:DW]   <= dqS;
            pendMask_reg[2*NL-1:NL]   <= ~bwsS;
            wrWord1_reg               <= 1'b0;
        end
    end

    // Older posted write reaches the array when the next write delivers data
    always_ff @(posedge core_clk) begin
        if (kRise && wrCmdV_reg && pendValid_reg) begin
            mem[{pendAddr_reg, 1'b0}] <= mergeBytes(mem[{pendAddr_reg, 1'b0}],
                                                    pendData_reg[DW-1:0],
                                                    pendMask_reg[NL-1:0]);
            mem[{pendAddr_reg, 1'b1}] <= mergeBytes(mem[{pendAddr_reg, 1'b1}],
                                                    pendData_reg[2*DW-1:DW],
                                                    pendMask_reg[2*NL-1:NL]);
        end
    end

    // Echo clocks, loop lock and impedance cadence
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            link.echoTimingOut      <= 1'b0;
            link.echoTimingOutCompl <= 1'b0;
            gapCnt_reg         <= '0;
            lockCnt_reg        <= '0;
            impCnt_reg         <= '0;
            loopLocked         <= 1'b0;
            impedanceTunePulse <= 1'b0;
        end else begin
            link.echoTimingOut      <= kS;
            link.echoTimingOutCompl <= knS;
            if (kS != kPrev_reg) begin
                gapCnt_reg <= '0;
            end else if (!stalled) begin
                gapCnt_reg <= gapCnt_reg + 4'h1;
            end
            // Only detects a stop longer than the nominal half period plus the loop reset time
            if (stalled || !dllOn) begin
                lockCnt_reg <= '0;
            end else if (kRise && lockCnt_reg != 12'(LOCK_CYCLES)) begin
                lockCnt_reg <= lockCnt_reg + 12'h001;
            end
            loopLocked <= dllOn && (lockCnt_reg == 12'(LOCK_CYCLES));
            if (kRise) begin
                impCnt_reg <= impCnt_reg + 10'h001;
            end
            impedanceTunePulse <= kRise &&
                (impCnt_reg == 10'(dbs_pkg::IMP_RETUNE_CYCLES - 1));
        end
    end
endmodule : dbs_device

// ==== dbs_controller.sv ====
`timescale 1ns/100ps
module dbs_controller (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    dbs_link_if.ctl          link,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [31:0] regRdData
);
    localparam int AW = dbs_pkg::ADDR_W;
    localparam int DW = dbs_pkg::WORD_W;
    localparam int CW = $clog2(dbs_pkg::K_PERIOD_CYC);

    typedef enum {ST_IDLE, ST_CMD, ST_WD0, ST_WD1, ST_RD} dbs_state_e;

    dbs_state_e    state_reg;
    logic [CW-1:0] cnt_reg;
    logic [AW-1:0] cfgAddr_reg;
    logic [DW-1:0] wData0_reg;
    logic [DW-1:0] wData1_reg;
    logic [DW-1:0] rData0_reg;
    logic [DW-1:0] rData1_reg;
    logic [3:0]    bwsCfg_reg;
    logic          clkStop_reg;
    logic          goRd_reg;
    logic          goWr_reg;
    logic          busy_reg;
    logic          got0_reg;
    logic [1:0]    turnCnt_reg;
    logic          cqPrev_reg;
    logic          cqnPrev_reg;
    logic [DW+2:0] syncIn;

    dbs_sync #(.W(DW+3)) uSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      ({link.echoTimingOut, link.echoTimingOutCompl, link.readValidFlag, link.dqBus}),
        .dout     (syncIn)
    );

    wire logic          cqRise  = syncIn[DW+2] & ~cqPrev_reg;
    wire logic          cqnRise = syncIn[DW+1] & ~cqnPrev_reg;
    wire logic          rvS     = syncIn[DW];
    wire logic [DW-1:0] dqS     = syncIn[DW-1:0];
    wire logic wrHit    = regWrStb && !busy_reg;
    wire logic ctrlWr   = regWrStb && (regAddr == dbs_pkg::REG_CTRL);
    wire logic startRd  = wrHit && ctrlWr && regWrData[dbs_pkg::CTRL_GO_READ];
    wire logic startWr  = wrHit && ctrlWr && !regWrData[dbs_pkg::CTRL_GO_READ]
                          && regWrData[dbs_pkg::CTRL_GO_WRITE];
    // Outputs move with the falling link clock, half a period before the rise
    wire logic fallEdge = (cnt_reg == CW'(dbs_pkg::K_HALF_CYC - 1)) && !clkStop_reg;
    wire logic wd1Edge  = (cnt_reg == CW'(dbs_pkg::WDATA1_CNT)) && !clkStop_reg;
    // Second word stays one cycle past the complementary rise, else the far end latches idle bus
    wire logic relEdge  = (cnt_reg == CW'(dbs_pkg::K_HALF_CYC)) && !clkStop_reg;
    wire logic [31:0] rdMux =
        (regAddr == dbs_pkg::REG_ADDR)   ? 32'(cfgAddr_reg) :
        (regAddr == dbs_pkg::REG_WDATA0) ? 32'(wData0_reg) :
        (regAddr == dbs_pkg::REG_WDATA1) ? 32'(wData1_reg) :
        (regAddr == dbs_pkg::REG_BWS)    ? 32'(bwsCfg_reg) :
        (regAddr == dbs_pkg::REG_CTRL)   ? 32'({clkStop_reg, link.loopDisableN, 2'b00}) :
        (regAddr == dbs_pkg::REG_STATUS) ? 32'(busy_reg) :
        (regAddr == dbs_pkg::REG_RDATA0) ? 32'(rData0_reg) :
        (regAddr == dbs_pkg::REG_RDATA1) ? 32'(rData1_reg) : 32'h00000000;

    // Register port and link clock divider
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfgAddr_reg       <= '0;
            wData0_reg        <= '0;
            wData1_reg        <= '0;
            bwsCfg_reg        <= dbs_pkg::BWS_RESET;
            clkStop_reg       <= 1'b0;
            link.loopDisableN <= dbs_pkg::LOOP_RESET;
            regRdData         <= '0;
            cnt_reg           <= '0;
            link.k            <= 1'b0;
            link.kn           <= 1'b1;
        end else begin
            regRdData <= regRdStb ? rdMux : 32'h00000000;
            if (regWrStb && regAddr == dbs_pkg::REG_ADDR)   cfgAddr_reg <= regWrData[AW-1:0];
            if (regWrStb && regAddr == dbs_pkg::REG_WDATA0) wData0_reg  <= regWrData[DW-1:0];
            if (regWrStb && regAddr == dbs_pkg::REG_WDATA1) wData1_reg  <= regWrData[DW-1:0];
            if (regWrStb && regAddr == dbs_pkg::REG_BWS)    bwsCfg_reg  <= regWrData[3:0];
            if (ctrlWr) begin
                link.loopDisableN <= regWrData[dbs_pkg::CTRL_LOOP_ON];
                clkStop_reg       <= regWrData[dbs_pkg::CTRL_CLK_STOP];
            end
            if (clkStop_reg) begin
                link.k  <= 1'b1;
                link.kn <= 1'b1;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= (cnt_reg == CW'(dbs_pkg::K_PERIOD_CYC - 1)) ? '0 : cnt_reg + CW'(1);
                link.k  <= (cnt_reg == CW'(dbs_pkg::K_PERIOD_CYC - 1)) ||
                           (cnt_reg < CW'(dbs_pkg::K_HALF_CYC - 1));
                link.kn <= !((cnt_reg == CW'(dbs_pkg::K_PERIOD_CYC - 1)) ||
                             (cnt_reg < CW'(dbs_pkg::K_HALF_CYC - 1)));
            end
        end
    end

    // Transfer sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg             <= ST_IDLE;
            goRd_reg              <= 1'b0;
            goWr_reg              <= 1'b0;
            busy_reg              <= 1'b0;
            got0_reg              <= 1'b0;
            turnCnt_reg           <= '0;
            rData0_reg            <= '0;
            rData1_reg            <= '0;
            cqPrev_reg            <= 1'b0;
            cqnPrev_reg           <= 1'b0;
            link.addr             <= '0;
            link.loadStrobeN      <= 1'b1;
            link.rw               <= 1'b1;
            link.byteWriteSelectN <= dbs_pkg::BWS_IDLE;
            link.ctlDq            <= '0;
            link.ctlDqOe          <= 1'b0;
        end else begin
            cqPrev_reg  <= syncIn[DW+2];
            cqnPrev_reg <= syncIn[DW+1];
            if (startRd || startWr) begin
                busy_reg <= 1'b1;
                goRd_reg <= startRd;
                goWr_reg <= startWr;
            end
            if (fallEdge && turnCnt_reg != 2'h0) begin
                turnCnt_reg <= turnCnt_reg - 2'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (fallEdge && (goRd_reg || (goWr_reg && turnCnt_reg == 2'h0))) begin
                        link.loadStrobeN <= 1'b0;
                        link.rw          <= goRd_reg;
                        link.addr        <= cfgAddr_reg;
                        goRd_reg         <= 1'b0;
                        goWr_reg         <= 1'b0;
                        if (goRd_reg) begin
                            turnCnt_reg <= 2'(dbs_pkg::TURN_NOPS);
                        end
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (fallEdge) begin
                        link.loadStrobeN <= 1'b1;
                        if (!link.rw) begin
                            link.ctlDq            <= wData0_reg;
                            link.byteWriteSelectN <= bwsCfg_reg[1:0];
                            link.ctlDqOe          <= 1'b1;
                            state_reg             <= ST_WD0;
                        end else begin
                            state_reg <= ST_RD;
                        end
                    end
                end
                ST_WD0: begin
                    if (wd1Edge) begin
                        link.ctlDq            <= wData1_reg;
                        link.byteWriteSelectN <= bwsCfg_reg[3:2];
                        state_reg             <= ST_WD1;
                    end
                end
                ST_WD1: begin
                    if (relEdge) begin
                        link.ctlDqOe          <= 1'b0;
                        link.byteWriteSelectN <= dbs_pkg::BWS_IDLE;
                        busy_reg              <= 1'b0;
                        state_reg             <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    if (cqRise && rvS) begin
                        rData0_reg <= dqS;
                        got0_reg   <= 1'b1;
                    end else if (cqnRise && got0_reg) begin
                        rData1_reg <= dqS;
                        got0_reg   <= 1'b0;
                        busy_reg   <= 1'b0;
                        state_reg  <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule : dbs_controller

// ==== dbs_link_assertions.sv ====
`timescale 1ns/100ps
module dbs_link_assertions (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic k,
    input wire logic kn,
    input wire logic loadStrobeN,
    input wire logic rw,
    input wire logic ctlDqOe,
    input wire logic devDqOe,
    input wire logic readValidFlag,
    input wire logic echoTimingOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_k_complement: assert property (k != kn)
        else $error("link clock pair not complementary");
    a_ld_on_fall: assert property ($changed(loadStrobeN) |-> $fell(k))
        else $error("load strobe moved off a link clock fall");
    a_ld_one_period: assert property ($fell(loadStrobeN) |-> !loadStrobeN[*8] ##1 loadStrobeN)
        else $error("load strobe not held one link period");
    a_wr_word_slot: assert property ($fell(loadStrobeN) && !rw |-> ##8 $rose(ctlDqOe))
        else $error("write data not driven one period after command");
    a_wr_data_span: assert property ($rose(ctlDqOe) |-> ctlDqOe[*8] ##1 ctlDqOe ##1 !ctlDqOe)
        else $error("write data window wrong length");
    a_no_bus_fight: assert property (!(ctlDqOe && devDqOe))
        else $error("both ends drive the data bus");
    a_flag_leads_data: assert property ($rose(devDqOe) |-> $past(readValidFlag, 3))
        else $error("read valid flag not early enough");
    a_burst_span: assert property ($rose(devDqOe) |-> devDqOe[*7] ##[1:2] !devDqOe)
        else $error("read burst drive length wrong");
    a_echo_follows_k: assert property (echoTimingOut == $past(k, 3))
        else $error("echo clock does not follow link clock");
    c_read: cover property ($rose(devDqOe));
    c_write: cover property ($rose(ctlDqOe));
    c_flag: cover property ($rose(readValidFlag));
endmodule : dbs_link_assertions

// ==== ddr_burst2_sram_port_tb.sv ====
`timescale 1ns/100ps
module ddr_burst2_sram_port_tb;
    localparam logic [17:0] W0 = 18'h1A5C3;
    localparam logic [17:0] W1 = 18'h2C3A5;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic [31:0] regRdData;
    logic [31:0] rdVal;
    logic        loopLocked;
    logic        impedanceTunePulse;
    int          err_total = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          tunes = 0;
    int          tuneAt = 0;
    int          tuneGap = 0;
    int          i;
    always #10 core_clk = ~core_clk;
    dbs_link_if dbs_link_if_inst ();
    dbs_device #(.LOCK_CYCLES(8)) dbs_device_inst (.core_clk(core_clk), .rstn(rstn),
        .link(dbs_link_if_inst.dev), .loopLocked(loopLocked),
        .impedanceTunePulse(impedanceTunePulse));
    dbs_controller dbs_controller_inst (.core_clk(core_clk), .rstn(rstn),
        .link(dbs_link_if_inst.ctl), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
    dbs_link_assertions dbs_link_assertions_inst (.core_clk(core_clk), .rstn(rstn),
        .k(dbs_link_if_inst.k), .kn(dbs_link_if_inst.kn),
        .loadStrobeN(dbs_link_if_inst.loadStrobeN), .rw(dbs_link_if_inst.rw),
        .ctlDqOe(dbs_link_if_inst.ctlDqOe), .devDqOe(dbs_link_if_inst.devDqOe),
        .readValidFlag(dbs_link_if_inst.readValidFlag),
        .echoTimingOut(dbs_link_if_inst.echoTimingOut));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // Tune interval measured in core cycles between pulses
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (rstn && impedanceTunePulse === 1'b1) begin
            tunes <= tunes + 1;
            tuneAt <= cycles;
            tuneGap <= cycles - tuneAt;
        end
        if (cycles == 30000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1 rdVal = regRdData;
    endtask : rd
    // One link operation, then poll busy with a bounded count
    task automatic op(logic [31:0] ad, logic [31:0] c, logic [31:0] d0, logic [31:0] d1,
                      logic [31:0] byte_write_select_n);
        int n;
        wr(dbs_pkg::REG_ADDR, ad);
        wr(dbs_pkg::REG_WDATA0, d0);
        wr(dbs_pkg::REG_WDATA1, d1);
        wr(dbs_pkg::REG_BWS, byte_write_select_n);
        wr(dbs_pkg::REG_CTRL, c);
        rdVal = 32'h1;
        for (n = 0; n < 100 && rdVal[0] !== 1'b0; n++) rd(dbs_pkg::REG_STATUS);
        chk("busy", 32'h0, rdVal);
        $display("test op %h at %h done", c, ad);
    endtask : op
    task automatic rdpair(logic [31:0] ad, logic [31:0] c, logic [17:0] e0, logic [17:0] e1);
        op(ad, c, 32'h0, 32'h0, 32'h0);
        rd(dbs_pkg::REG_RDATA0);
        chk("rdata0", {14'h0, e0}, rdVal);
        rd(dbs_pkg::REG_RDATA1);
        chk("rdata1", {14'h0, e1}, rdVal);
    endtask : rdpair
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd(dbs_pkg::REG_CTRL);
        chk("ctrl", 32'h4, rdVal & 32'hC);
        rd(4'hF);
        chk("unmapped", 32'h0, rdVal);
        for (i = 0; i < 300 && loopLocked !== 1'b1; i++) @(posedge core_clk);
        chk("locked", 32'h1, {31'h0, loopLocked});
        $display("test reset and lock done");
        op(32'h12345, 32'h6, {14'h0, W0}, {14'h0, W1}, 32'h0);
        rdpair(32'h12345, 32'h5, W0, W1);
        op(32'h12345, 32'h6, 32'h3FFFF, 32'h0, 32'h6);
        op(32'h00777, 32'h6, 32'h15555, 32'h0AAAA, 32'h0);
        rdpair(32'h12345, 32'h5, {W0[17:9], 9'h1FF}, {9'h0, W1[8:0]});
        rdpair(32'h00777, 32'h1, 18'h15555, 18'h0AAAA);
        for (i = 0; i < 20000 && tunes < 2; i++) @(posedge core_clk);
        chk("tunegap", 32'd1024 * dbs_pkg::K_PERIOD_CYC, 32'(tuneGap));
        $display("test retune interval done");
        complete_run();
    end
endmodule : ddr_burst2_sram_port_tb
